//--- hdl/hubarb_pkg.sv
package hubarb_pkg;

   // Address header layout: four local id bits, three hub id bits, one direction bit.
   localparam int          LOCAL_ID_W      = 4;
   localparam int          HUB_ID_W        = 3;
   localparam int          HDR_BITS        = 8;
   localparam logic [3:0]  HUB_LOCAL_ID    = 4'ha;
   localparam logic [2:0]  WILDCARD_HUB_ID = 3'h7;
   localparam logic [3:0]  LOCAL_ID_BAD_LO = 4'h0;
   localparam logic [3:0]  LOCAL_ID_BAD_HI = 4'hf;
   localparam logic [2:0]  HUB_ID_RESET    = 3'h0;

   // Bus idle time before a request may be raised.
   localparam int          CLK_MHZ        = 200;
   localparam int          AVAIL_US       = 1;
   localparam int          AVAIL_CYC      = AVAIL_US * CLK_MHZ;
   localparam int          BITCNT_W       = 4;

   // Cycles after a host clock fall before the echo compare is trusted.
   localparam int          ECHO_SETTLE    = 3;

   // Open-drain pin: input level, drive-low enable.
   typedef struct packed {
      logic sda_in;
      logic scl_in;
   } hubarb_pins_in_t;

   typedef struct packed {
      logic sda_oe;
      logic sda_out;
   } hubarb_pin_out_t;

endpackage : hubarb_pkg

//--- hdl/hubarb_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser for a level arriving from outside the clock domain.
module hubarb_sync
   import hubarb_pkg::*;
#(
   parameter int W = 2
)
(
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   // The first stage is read by the second stage only.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_ff <= '1;
         q_ff    <= '1;
      end
      else
      begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end

   assign q = q_ff;

endmodule : hubarb_sync

//--- hdl/hubarb_arbiter.sv
`timescale 1ns/1ps

// How it works
// - Hub sends local id 1010, lower hub id wins.
// - Hub losing to another hub releases, retries later.
// - Local ids 0001..1110 valid, 1010 is hub.
// - Relay winning local id bits to host.
// - Replace wildcard bits with own hub id.
// - Echo match as 1, mismatch as 0 locally.
// - Local below 1010 beats hub, above loses.
// - Lowest local id wins across all hubs.
// - Equal local ids resolved by lower hub id.
// - Arbitrate after bus idle for availability time.
module hubarb_arbiter
   import hubarb_pkg::*;
#(
   parameter int AVAIL_CYCLES = AVAIL_CYC
)
(
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic [HUB_ID_W-1:0]   hub_id_code,
   input  wire logic                  hub_req,
   input  wire hubarb_pins_in_t       host_pins,
   input  wire hubarb_pins_in_t       local_pins,
   output hubarb_pin_out_t            host_sda,
   output hubarb_pin_out_t            local_sda,
   output logic                       arb_active,
   output logic                       hub_won,
   output logic                       hub_lost,
   output logic [LOCAL_ID_W-1:0]      win_local_id_code
);

   // Header phases: local id bits, hub id bits, then the direction bit.
   typedef enum logic [3:0] {
      HUBARB_IDLE  = 4'h1,
      HUBARB_LOCAL = 4'h2,
      HUBARB_HUBID = 4'h4,
      HUBARB_DIR   = 4'h8
   } hubarb_state_t;

   localparam int IDLE_W = $clog2(AVAIL_CYCLES + 1);

   hubarb_state_t           state_ff;
   hubarb_state_t           nxt_state;
   logic [1:0]              hsync;
   logic [1:0]              lsync;
   logic                    h_sda;
   logic                    h_scl;
   logic                    l_sda;
   logic                    hscl_d_ff;
   logic [IDLE_W-1:0]       idle_ff;
   logic [BITCNT_W-1:0]     bit_ff;
   logic [BITCNT_W-1:0]     settle_ff;
   logic                    hub_drv_ff;
   logic                    hub_bit_ff;
   logic                    echo_ff;
   logic                    relay_ff;
   logic [LOCAL_ID_W-1:0]   loc_id_ff;
   logic                    won_ff;
   logic                    lost_ff;

   // Both buses are asynchronous to clk, so every pin passes two flops first.
   hubarb_sync #(
      .W(2)
   ) u_hsync (
      .clk  (clk),
      .rst_b(rst_b),
      .d    ({host_pins.sda_in, host_pins.scl_in}),
      .q    (hsync)
   );

   // The local clock is not needed: the local bus follows the host clock.
   hubarb_sync #(
      .W(2)
   ) u_lsync (
      .clk  (clk),
      .rst_b(rst_b),
      .d    ({local_pins.sda_in, local_pins.scl_in}),
      .q    (lsync)
   );

   assign h_sda = hsync[1];
   assign h_scl = hsync[0];
   assign l_sda = lsync[1];

   // Edge and idle decode on the synchronised host clock.
   wire scl_rise   = h_scl & ~hscl_d_ff;
   wire scl_fall   = ~h_scl & hscl_d_ff;
   wire in_local   = (state_ff == HUBARB_LOCAL);
   wire in_hub_id  = (state_ff == HUBARB_HUBID);
   wire bus_idle   = (idle_ff == IDLE_W'(AVAIL_CYCLES));
   wire start_req  = bus_idle & ~h_sda;
   wire last_bit   = (bit_ff == BITCNT_W'(HDR_BITS - 1));
   wire dir_slot   = (bit_ff >= BITCNT_W'(HDR_BITS - 1));
   wire local_slot = (bit_ff < BITCNT_W'(LOCAL_ID_W));

   // Bit the hub puts on the host line for the slot that follows this fall.
   // The direction slot is always released, so it reads back as a one.
   wire hub_id_bit = dir_slot   ? 1'b1 :
                     local_slot ? HUB_LOCAL_ID[LOCAL_ID_W - 1 - bit_ff] :
                                  hub_id_code[HDR_BITS - 2 - bit_ff];

   // What the relayed local requester is contending with in this slot:
   // its own line during the local id, the substituted hub id afterwards.
   wire relay_bit  = in_hub_id ? hub_bit_ff : l_sda;
   wire relay_lose = relay_ff & relay_bit & ~h_sda & (in_local | in_hub_id);
   wire hub_lose   = hub_drv_ff & hub_bit_ff & ~h_sda & ~last_bit;

   // The hub drives only zeros; a one is released and read back.
   // During the hub id slots it also speaks for a local requester still in
   // contention, since the wildcard bits never reach the host.
   wire hub_pull   = (hub_drv_ff | (in_hub_id & relay_ff)) & ~hub_bit_ff;
   wire relay_pull = in_local & relay_ff & ~l_sda;

   // Phase sequencing counts host clock rises.
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         HUBARB_IDLE:  if (start_req) nxt_state = HUBARB_LOCAL;
         HUBARB_LOCAL: if (scl_rise && bit_ff == BITCNT_W'(LOCAL_ID_W - 1)) nxt_state = HUBARB_HUBID;
         HUBARB_HUBID: if (scl_rise && bit_ff == BITCNT_W'(HDR_BITS - 2)) nxt_state = HUBARB_DIR;
         HUBARB_DIR:   if (scl_rise) nxt_state = HUBARB_IDLE;
         default:      nxt_state = HUBARB_IDLE;
      endcase
   end

   // Idle timer: any host clock edge restarts the availability interval.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         idle_ff <= '0;
      else if (scl_rise || scl_fall || state_ff != HUBARB_IDLE)
         idle_ff <= '0;
      else if (!bus_idle)
         idle_ff <= idle_ff + IDLE_W'(1);
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_ff  <= HUBARB_IDLE;
         hscl_d_ff <= 1'b1;
      end
      else
      begin
         state_ff  <= nxt_state;
         hscl_d_ff <= h_scl;
      end
   end

   // Bit counter and per-bit arbitration, sampled on host clock rise.
   // The result flags stand until the next frame opens, so that whoever
   // reads them after the header still finds the outcome.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bit_ff     <= '0;
         hub_drv_ff <= 1'b0;
         hub_bit_ff <= 1'b1;
         relay_ff   <= 1'b0;
         loc_id_ff  <= '0;
         won_ff     <= 1'b0;
         lost_ff    <= 1'b0;
      end
      else if (state_ff == HUBARB_IDLE)
      begin
         bit_ff     <= '0;
         hub_drv_ff <= start_req & hub_req;
         hub_bit_ff <= HUB_LOCAL_ID[LOCAL_ID_W-1];
         relay_ff   <= start_req & ~l_sda;
         if (start_req)
         begin
            won_ff  <= 1'b0;
            lost_ff <= 1'b0;
         end
      end
      else if (scl_fall)
         hub_bit_ff <= hub_id_bit;
      else if (scl_rise)
      begin
         bit_ff <= bit_ff + BITCNT_W'(1);
         if (in_local)
            loc_id_ff <= {loc_id_ff[LOCAL_ID_W-2:0], h_sda};
         // Hub drove 1 but sees 0: it lost and releases the line.
         if (hub_lose)
         begin
            hub_drv_ff <= 1'b0;
            lost_ff    <= 1'b1;
         end
         // A relayed requester that lost is no longer spoken for.
         if (relay_lose)
            relay_ff <= 1'b0;
         if (last_bit)
            won_ff <= hub_drv_ff;
      end
   end

   // Echo of the hub id compare toward the local bus.
   // The local requester samples its line at the host clock rise, so the
   // verdict for a slot must be in place before that rise. It is taken a
   // few cycles after the fall, once the substituted bit has crossed the
   // synchroniser, and the line is released in between to avoid a glitch.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         settle_ff <= '0;
         echo_ff   <= 1'b1;
      end
      else if (!in_hub_id)
      begin
         settle_ff <= '0;
         echo_ff   <= 1'b1;
      end
      else if (scl_fall)
      begin
         settle_ff <= BITCNT_W'(ECHO_SETTLE);
         echo_ff   <= 1'b1;
      end
      else if (settle_ff != '0)
      begin
         settle_ff <= settle_ff - BITCNT_W'(1);
         if (settle_ff == BITCNT_W'(1))
            echo_ff <= (h_sda == hub_bit_ff);
      end
   end

   // Open-drain outputs: drive low only.
   assign host_sda.sda_out  = 1'b0;
   assign host_sda.sda_oe   = hub_pull | relay_pull;
   assign local_sda.sda_out = 1'b0;
   assign local_sda.sda_oe  = in_hub_id & ~echo_ff;

   // Status seen by the rest of the hub.
   assign arb_active        = (state_ff != HUBARB_IDLE);
   assign hub_won           = won_ff;
   assign hub_lost          = lost_ff;
   assign win_local_id_code = loc_id_ff;

endmodule : hubarb_arbiter

//--- test/hubarb_chk_sva.sv
`timescale 1ns/1ps
// Watches the arbiter pins; every check is gated off while reset is low.
module hubarb_chk
   import hubarb_pkg::*;
(
   input wire logic             clk,
   input wire logic             rst_b,
   input wire logic             hub_req,
   input wire hubarb_pins_in_t  host_pins,
   input wire hubarb_pin_out_t  host_sda,
   input wire hubarb_pin_out_t  local_sda,
   input wire logic             arb_active,
   input wire logic             hub_won,
   input wire logic             hub_lost,
   input wire logic [LOCAL_ID_W-1:0] win_local_id_code
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Open drain: a pin is only ever pulled low, never driven high.
   property p_host_od; host_sda.sda_out == 1'b0; endproperty
   a_host_od: assert property (p_host_od) else $error("host data driven high");
   property p_loc_od; local_sda.sda_out == 1'b0; endproperty
   a_loc_od: assert property (p_loc_od) else $error("local data driven high");
   property p_excl; !(hub_won && hub_lost); endproperty
   a_excl: assert property (p_excl) else $error("won and lost together");
   property p_echo_idle; !arb_active |-> !local_sda.sda_oe; endproperty
   a_echo_idle: assert property (p_echo_idle) else $error("echo outside header");
   property p_won_id; hub_won |-> win_local_id_code == HUB_LOCAL_ID; endproperty
   a_won_id: assert property (p_won_id) else $error("hub won with other id");
   property p_won_req; $rose(hub_won) |-> $past(hub_req); endproperty
   a_won_req: assert property (p_won_req) else $error("won without request");
   property p_start; $rose(arb_active) |-> !host_pins.sda_in; endproperty
   a_start: assert property (p_start) else $error("header without start");
   property p_lost_hold; hub_lost && arb_active |=> hub_lost; endproperty
   a_lost_hold: assert property (p_lost_hold) else $error("lost flag dropped");
   // Main outcomes reached by the bench.
   c_won: cover property (hub_won);
   c_lost: cover property (hub_lost);
   c_echo: cover property (local_sda.sda_oe);
endmodule : hubarb_chk
bind hubarb_arbiter hubarb_chk u_chk (.clk, .rst_b, .hub_req, .host_pins, .host_sda, .local_sda,
   .arb_active, .hub_won, .hub_lost, .win_local_id_code);

//--- test/hubarb_far.sv
`timescale 1ns/1ps
// Host, one rival requester on the host bus and one local requester.
module hubarb_far
   import hubarb_pkg::*;
(
   input  wire logic       host_oe,
   input  wire logic       local_oe,
   output hubarb_pins_in_t host_pins,
   output hubarb_pins_in_t local_pins
);
   logic scl = 1'b1;
   logic eb  = 1'b1;
   logic lb  = 1'b1;
   // Wired-AND lines with pull-ups; the local bus shares the host clock.
   assign host_pins  = {eb & ~host_oe, scl};
   assign local_pins = {lb & ~local_oe, scl};
   // Bits move while the clock is low and are sampled at its rise.
   task automatic frame(input logic e_on, input logic [6:0] ec, input logic l_on,
                        input logic [3:0] loc, output logic [2:0] echo);
      logic [7:0] eh;
      logic [7:0] lh;
      eh = e_on ? {ec, 1'b1} : 8'hff;
      lh = l_on ? {loc, 4'hf} : 8'hff;
      // Every contest opens with a start, even when only the hub requests.
      eb = 1'b0;
      lb = ~l_on;
      #80 scl = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         eb = eh[i];
         lb = lh[i];
         #40 scl = 1'b1;
         if (eb && !host_pins.sda_in) eh = 8'hff;
         if (i inside {[1:3]}) echo[i-1] = local_pins.sda_in;
         #40 scl = 1'b0;
      end
   endtask : frame
   task automatic stop;
      eb = 1'b0;
      #40 scl = 1'b1;
      #40 eb = 1'b1;
   endtask : stop
endmodule : hubarb_far

//--- test/test_hub_ibi_arbitration.sv
`timescale 1ns/1ps
module test_hub_ibi_arbitration
   import hubarb_pkg::*;
;
   logic            clk = 1'b0;
   logic            rst_b = 1'b0;
   logic            hub_req = 1'b0;
   logic [2:0]      hub_code = 3'h0;
   logic            act;
   hubarb_pins_in_t host_pins;
   hubarb_pins_in_t local_pins;
   hubarb_pin_out_t host_sda;
   hubarb_pin_out_t local_sda;
   logic            won;
   logic            lost;
   logic [3:0]      win_id;
   logic [2:0]      echo;
   int              num_errors = 0;
   int              n_tests = 0;
   int              cyc = 0;
   always #2.5 clk = ~clk;
   hubarb_far u_far (.host_oe(host_sda.sda_oe), .local_oe(local_sda.sda_oe), .host_pins, .local_pins);
   // A short idle count keeps each frame gap brief.
   hubarb_arbiter #(.AVAIL_CYCLES(20)) u_dut (.clk, .rst_b, .hub_id_code(hub_code), .hub_req, .host_pins,
      .local_pins, .host_sda, .local_sda, .arb_active(act), .hub_won(won), .hub_lost(lost), .win_local_id_code(win_id));
   task automatic chk(input string nm, input logic [6:0] exp, input logic [6:0] got);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   // A hang counts as a mismatch.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         num_errors++;
         end_sim();
      end
   end
   // Random contests; the lowest {local id, hub id} code is expected to win.
   initial
   begin
      int e, l, el, ll, eh, h, rq, b;
      void'($urandom(32'h8315));
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      for (int t = 0; t < 60; t++)
      begin
         repeat (100) @(posedge clk);
         h = $urandom % 8;
         rq = $urandom % 2;
         e = $urandom % 2;
         l = ($urandom % 2) | !(e | rq);
         ll = 1 + $urandom % 14;
         ll = ll == 10 ? 9 : ll;
         el = ll + $urandom % (15 - ll);
         eh = (h + 1 + $urandom % 7) % 8;
         hub_code <= 3'(h);
         hub_req <= 1'(rq);
         b = e ? el * 8 + eh : 255;
         b = l && ll * 8 + h < b ? ll * 8 + h : b;
         b = rq && 80 + h < b ? 80 + h : b;
         u_far.frame(1'(e), 7'(el * 8 + eh), 1'(l), 4'(ll), echo);
         chk("win id", 7'(b / 8), {3'h0, win_id});
         chk("won", 7'(rq && b == 80 + h), {6'h0, won});
         chk("lost", 7'(rq && b != 80 + h), {6'h0, lost});
         if (l) chk("echo", 7'(~(b ^ h) & 7), {4'h0, echo});
         chk("active", 7'h0, {6'h0, act});
         u_far.stop();
      end
      end_sim();
   end
endmodule : test_hub_ibi_arbitration
